// file: design/tw_cfg_mem.sv
/*
 * Eight-byte configuration store with one write port and a registered read.
 * Assumes writes arrive as single-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
module tw_cfg_mem import tw_pkg::*; (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire tw_wr_type wr_i,
	input wire logic [CFG_AW-1:0] rd_addr_i,
	output logic [7:0] rd_data_o
);

	logic [7:0] mem_reg [CFG_DEPTH];
	logic [7:0] mem_next [CFG_DEPTH];
	logic [7:0] rd_next;

	// ==========================================================
	// Storage, one entry per configuration byte
	genvar i;
	generate
		for (i = 0; i < CFG_DEPTH; i++) begin : g_ent
			always_comb begin
				mem_next[i] = mem_reg[i];
				if (wr_i.valid && (wr_i.addr == CFG_AW'(i))) begin
					mem_next[i] = wr_i.data;
				end
			end
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					mem_reg[i] <= CFG_RESET[i*8 +: 8];
				end else begin
					mem_reg[i] <= mem_next[i];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Registered read
	always_comb begin
		rd_next = mem_reg[rd_addr_i];
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= rd_next;
		end
	end

endmodule // tw_cfg_mem

// file: design/tw_cfg_slave.sv
/*
 * Two-wire configuration slave: address match, command byte, byte and word
 * writes and reads of the configuration store, and the lock status output.
 * Assumes SCL and SDA are pulled up outside and that SCL runs no faster than
 * fast mode, far below the 40 MHz system clock that samples it.
 */
// How it works
// - Slave only, fast mode up to 400 kbit/s
// - Address is fixed 11010 plus two straps
// - Eighth address bit: 0 write, 1 read
// - Answer only the strap-selected address
// - Status output high while PLL locked
// - SDA open-drain; SCL input only
// - Command byte: access flag, seven-bit offset
// - Byte write: acknowledge every received byte
// - Read: command write, restart, data, NACK
// - Word access: offset then next, last alone
`timescale 1ns/1ps
module tw_cfg_slave import tw_pkg::*; (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic addr_strap_hi_i,
	input wire logic addr_strap_lo_i,
	input wire logic pll_locked_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic lock_status_o,
	output tw_wr_type cfg_wr_o
);

	tw_pins_type pin_s1, pin_s2, pin_now;
	logic scl_d, sda_d;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [6:0] own_addr;
	tw_state_type state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic rw_reg, rw_next;
	logic cmd_seen_reg, cmd_seen_next;
	logic acc_reg, acc_next;
	logic [6:0] ptr_reg, ptr_next;
	logic oe_n_reg, oe_n_next;
	logic lock_reg, lock_next;
	tw_wr_type wr_reg, wr_next;
	logic [7:0] mem_rd, rd_byte;
	logic ptr_ok, wr_ok;

	// ==========================================================
	// Pin synchronisers and edge detection
	always_comb begin
		pin_now = '{scl: scl_i, sda: sda_i, strap_hi: addr_strap_hi_i,
			strap_lo: addr_strap_lo_i, pll_lock: pll_locked_i};
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pin_s1 <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			pin_s2 <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			pin_s1 <= pin_now;
			pin_s2 <= pin_s1;
			scl_d <= pin_s2.scl;
			sda_d <= pin_s2.sda;
		end
	end

	// SCL is only ever sampled here, never driven
	assign scl_rise = pin_s2.scl && !scl_d;
	assign scl_fall = !pin_s2.scl && scl_d;
	assign start_det = pin_s2.scl && scl_d && sda_d && !pin_s2.sda;
	assign stop_det = pin_s2.scl && scl_d && !sda_d && pin_s2.sda;
	assign own_addr = {FIXED_ADDR_BITS, pin_s2.strap_hi, pin_s2.strap_lo};

	// ==========================================================
	// Configuration store and read data
	tw_cfg_mem u_mem (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(wr_reg),
		.rd_addr_i(ptr_reg[CFG_AW-1:0]),
		.rd_data_o(mem_rd)
	);

	assign ptr_ok = acc_reg && (ptr_reg < CFG_END);
	assign wr_ok = ptr_ok && (ptr_reg != RO_OFFSET);

	always_comb begin
		rd_byte = IDLE_BYTE;
		if (ptr_ok) begin
			rd_byte = (ptr_reg == RO_OFFSET) ? {lock_reg, RSVD_LOW_BITS} : mem_rd;
		end
	end

	// ==========================================================
	// Protocol engine
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		rw_next = rw_reg;
		cmd_seen_next = cmd_seen_reg;
		acc_next = acc_reg;
		ptr_next = ptr_reg;
		oe_n_next = oe_n_reg;
		wr_next = '0;
		lock_next = pin_s2.pll_lock;
		if (start_det) begin
			state_next = TW_ADDR;
			cnt_next = '0;
			cmd_seen_next = 1'b0;
			oe_n_next = 1'b1;
		end else if (stop_det) begin
			state_next = TW_IDLE;
			oe_n_next = 1'b1;
		end else begin
			case (state_reg)
				TW_ADDR: if (scl_rise) begin
					shift_next = {shift_reg[6:0], pin_s2.sda};
					cnt_next = cnt_reg + BIT_STEP;
					if (cnt_reg == BIT_LAST) begin
						if (shift_reg[6:0] == own_addr) begin
							rw_next = pin_s2.sda;
							state_next = TW_ACK_WAIT;
						end else begin
							state_next = TW_IDLE;
						end
					end
				end
				TW_RX: if (scl_rise) begin
					shift_next = {shift_reg[6:0], pin_s2.sda};
					cnt_next = cnt_reg + BIT_STEP;
					if (cnt_reg == BIT_LAST) begin
						state_next = TW_ACK_WAIT;
						if (!cmd_seen_reg) begin
							cmd_seen_next = 1'b1;
							acc_next = shift_reg[CMD_FLAG_POS];
							ptr_next = {shift_reg[5:0], pin_s2.sda};
						end else begin
							if (wr_ok) begin
								wr_next = '{valid: 1'b1, addr: ptr_reg[CFG_AW-1:0],
									data: {shift_reg[6:0], pin_s2.sda}};
							end
							if (ptr_reg < CFG_END) begin
								ptr_next = ptr_reg + PTR_STEP;
							end
						end
					end
				end
				TW_ACK_WAIT: if (scl_fall) begin
					oe_n_next = 1'b0;
					state_next = TW_ACK_HOLD;
				end
				TW_ACK_HOLD: if (scl_fall) begin
					oe_n_next = 1'b1;
					cnt_next = '0;
					state_next = rw_reg ? TW_TX_LOAD : TW_RX;
				end
				TW_TX_LOAD: begin
					shift_next = rd_byte;
					oe_n_next = rd_byte[7];
					cnt_next = '0;
					state_next = TW_TX;
				end
				TW_TX: if (scl_fall) begin
					shift_next = {shift_reg[6:0], 1'b1};
					oe_n_next = shift_reg[6];
				end else if (scl_rise) begin
					cnt_next = cnt_reg + BIT_STEP;
					if (cnt_reg == BIT_LAST) begin
						state_next = TW_ACK_IN;
						if (ptr_reg < CFG_END) begin
							ptr_next = ptr_reg + PTR_STEP;
						end
					end
				end
				TW_ACK_IN: if (scl_fall) begin
					oe_n_next = 1'b1;
				end else if (scl_rise) begin
					state_next = pin_s2.sda ? TW_IDLE : TW_TX_WAIT;
				end
				TW_TX_WAIT: if (scl_fall) begin
					state_next = TW_TX_LOAD;
				end
				TW_IDLE: begin
					oe_n_next = 1'b1;
				end
				default: begin
					state_next = TW_IDLE;
					oe_n_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_reg <= TW_IDLE;
			cnt_reg <= '0;
			shift_reg <= '0;
			rw_reg <= 1'b0;
			cmd_seen_reg <= 1'b0;
			acc_reg <= 1'b0;
			ptr_reg <= '0;
			oe_n_reg <= 1'b1;
			lock_reg <= 1'b0;
			wr_reg <= '0;
			sda_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			rw_reg <= rw_next;
			cmd_seen_reg <= cmd_seen_next;
			acc_reg <= acc_next;
			ptr_reg <= ptr_next;
			oe_n_reg <= oe_n_next;
			lock_reg <= lock_next;
			wr_reg <= wr_next;
			sda_o <= 1'b0;
		end
	end

	assign sda_oe_n_o = oe_n_reg;
	assign lock_status_o = lock_reg;
	assign cfg_wr_o = wr_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	a_addr_match_ack: assert property (!start_det && !stop_det && state_reg == TW_ADDR
		&& scl_rise && cnt_reg == BIT_LAST && shift_reg[6:0] == own_addr
		|=> state_reg == TW_ACK_WAIT ##0 rw_reg == $past(pin_s2.sda))
		else $error("matching address not taken");
	a_addr_fixed_bits: assert property (!start_det && !stop_det && state_reg == TW_ADDR
		&& scl_rise && cnt_reg == BIT_LAST && shift_reg[6:2] != FIXED_ADDR_BITS
		|=> state_reg != TW_ACK_WAIT)
		else $error("address with foreign fixed bits taken");
	a_mismatch_idle: assert property (!start_det && !stop_det && state_reg == TW_ADDR
		&& scl_rise && cnt_reg == BIT_LAST && shift_reg[6:0] != own_addr
		|=> state_reg == TW_IDLE ##1 sda_oe_n_o)
		else $error("foreign address answered");
	a_ack_drive: assert property (!start_det && !stop_det && state_reg == TW_ACK_WAIT
		&& scl_fall |=> !sda_oe_n_o throughout (!scl_fall [*2]))
		else $error("acknowledge not driven");
	a_read_dir: assert property (state_reg == TW_ACK_HOLD && rw_reg && scl_fall
		&& !start_det && !stop_det |=> state_reg == TW_TX_LOAD ##1 state_reg == TW_TX)
		else $error("read direction not served");
	a_cmd_capture: assert property (!start_det && !stop_det && state_reg == TW_RX
		&& !cmd_seen_reg && scl_rise && cnt_reg == BIT_LAST
		|=> ptr_reg == {$past(shift_reg[5:0]), $past(pin_s2.sda)}
		&& acc_reg == $past(shift_reg[6]))
		else $error("command byte misread");
	a_word_next: assert property (cfg_wr_o.valid |-> ptr_reg == {4'h0, cfg_wr_o.addr}
		+ PTR_STEP && cfg_wr_o.addr != RO_OFFSET[CFG_AW-1:0] ##1 !cfg_wr_o.valid)
		else $error("write offset sequence broken");
	a_lock_follow: assert property ($changed(pin_s2.pll_lock)
		|=> lock_status_o == $past(pin_s2.pll_lock))
		else $error("lock status not following");
	a_sda_only_low: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	a_sda_released: assert property (state_reg inside {TW_IDLE, TW_ADDR, TW_RX}
		|-> sda_oe_n_o)
		else $error("data line pulled while master drives");
	a_nack_ends: assert property (state_reg == TW_ACK_IN && scl_rise && pin_s2.sda
		&& !start_det && !stop_det |=> state_reg == TW_IDLE)
		else $error("read not ended by not-acknowledge");

	c_byte_write: cover property (cfg_wr_o.valid);
	c_read_byte: cover property (state_reg == TW_ACK_IN && scl_rise && pin_s2.sda);
	c_word_read: cover property (state_reg == TW_ACK_IN && scl_rise && !pin_s2.sda);
	c_foreign: cover property (state_reg == TW_ADDR && scl_rise && cnt_reg == BIT_LAST
		&& shift_reg[6:0] != own_addr);

endmodule // tw_cfg_slave

// file: design/tw_pkg.sv
/*
 * Shared constants, types and states of the two-wire configuration slave.
 * Assumes a single 40 MHz system clock and a bus master that follows
 * fast-mode two-wire timing.
 */
package tw_pkg;

	// ==========================================================
	// Address and command layout
	localparam logic [4:0] FIXED_ADDR_BITS = 5'h1A;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;
	localparam int CMD_FLAG_POS = 6;
	localparam logic [6:0] PTR_STEP = 7'h01;

	// ==========================================================
	// Configuration store
	localparam int CFG_DEPTH = 8;
	localparam int CFG_AW = 3;
	localparam logic [6:0] CFG_END = 7'h08;
	localparam logic [6:0] RO_OFFSET = 7'h00;
	localparam logic [6:0] RSVD_LOW_BITS = 7'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [CFG_DEPTH*8-1:0] CFG_RESET = 64'h0000_0000_0000_2000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic scl;
		logic sda;
		logic strap_hi;
		logic strap_lo;
		logic pll_lock;
	} tw_pins_type;

	typedef struct packed {
		logic valid;
		logic [CFG_AW-1:0] addr;
		logic [7:0] data;
	} tw_wr_type;

	typedef enum logic [3:0] {
		TW_IDLE,
		TW_ADDR,
		TW_RX,
		TW_ACK_WAIT,
		TW_ACK_HOLD,
		TW_TX_LOAD,
		TW_TX,
		TW_ACK_IN,
		TW_TX_WAIT
	} tw_state_type;

endpackage

// file: tb/tb_top.sv
/* Self-checking bench of the two-wire configuration slave.
   Assumes the master model drives the link and SDA has a pull-up. */
`timescale 1ns/1ps
module tb_top import tw_pkg::*; ;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] dat;
		logic [7:0] rd;
		logic [7:0] nw;
	} tw_row_type;
	logic mclk, sys_rst, scl, sda_drv, st_hi, st_lo, pll, sda_o, sda_oe_n, lock_st, ak;
	logic [7:0] q;
	tw_wr_type cfg_wr, last_wr;
	wire sda = sda_drv & (sda_oe_n ? 1'b1 : sda_o);
	int fails = 0, n_compared = 0, cyc = 0, wr_cnt = 0, n;
	tw_row_type rows [5] = '{'{8'h81, 8'h5A, 8'h5A, 8'h01}, '{8'h87, 8'hC3, 8'hC3, 8'h01},
		'{8'h80, 8'h55, 8'h00, 8'h00}, '{8'h88, 8'h11, 8'hFF, 8'h00},
		'{8'h01, 8'h33, 8'hFF, 8'h00}};
	tw_cfg_slave tw_cfg_slave_inst (.mclk_i(mclk), .sys_rst_i(sys_rst), .scl_i(scl),
		.sda_i(sda), .addr_strap_hi_i(st_hi), .addr_strap_lo_i(st_lo), .pll_locked_i(pll),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .lock_status_o(lock_st), .cfg_wr_o(cfg_wr));
	tw_master_model tw_master_model_inst (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
		.sda_drv_o(sda_drv));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ==========================================================
	// Write monitor and timeout
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cfg_wr.valid === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			last_wr <= cfg_wr;
		end
		if (cyc == 30000) begin
			fails = fails + 1;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] adr(input logic rw);
		return {FIXED_ADDR_BITS, st_hi, st_lo, rw};
	endfunction
	task automatic wb(input string nm, input logic [7:0] b, input logic ea);
		tw_master_model_inst.xb(b, 1'b1, q, ak);
		chk(nm, {7'h00, ak}, {7'h00, ea});
	endtask
	task automatic wr_tx(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
		input int nb);
		tw_master_model_inst.cond(1'b1, 1'b0);
		wb("addr ack", adr(1'b0), 1'b0);
		wb("cmd ack", cmd, 1'b0);
		wb("data ack", d0, 1'b0);
		if (nb > 1)
			wb("data ack", d1, 1'b0);
		tw_master_model_inst.cond(1'b0, 1'b1);
	endtask
	task automatic rd_tx(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1,
		input int nb);
		tw_master_model_inst.cond(1'b1, 1'b0);
		wb("addr ack", adr(1'b0), 1'b0);
		wb("cmd ack", cmd, 1'b0);
		tw_master_model_inst.cond(1'b1, 1'b0);
		wb("raddr ack", adr(1'b1), 1'b0);
		tw_master_model_inst.xb(8'hFF, nb == 1, q, ak);
		chk("rd0", q, e0);
		if (nb > 1) begin
			tw_master_model_inst.xb(8'hFF, 1'b1, q, ak);
			chk("rd1", q, e1);
		end
		tw_master_model_inst.cond(1'b0, 1'b1);
	endtask
	task automatic rst_pulse();
		sys_rst = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		st_hi = 1'b0;
		st_lo = 1'b1;
		pll = 1'b0;
		rst_pulse();
		foreach (rows[i]) begin
			n = wr_cnt;
			wr_tx(rows[i].cmd, rows[i].dat, 8'h00, 1);
			chk("writes", 8'(wr_cnt - n), rows[i].nw);
			if (rows[i].nw != 8'h00) begin
				chk("wr data", last_wr.data, rows[i].dat);
				chk("wr addr", {5'h00, last_wr.addr}, {5'h00, rows[i].cmd[2:0]});
			end
			rd_tx(rows[i].cmd, rows[i].rd, 8'h00, 1);
		end
		$display("test table done");
		n = wr_cnt;
		wr_tx(8'h86, 8'h11, 8'h22, 2);
		wr_tx(8'h87, 8'h44, 8'h55, 2);
		chk("word writes", 8'(wr_cnt - n), 8'h03);
		rd_tx(8'h86, 8'h11, 8'h44, 2);
		rd_tx(8'h87, 8'h44, 8'hFF, 2);
		rd_tx(8'h81, 8'h5A, 8'h00, 1);
		$display("test word done");
		pll = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk("lock", {7'h00, lock_st}, 8'h01);
		rd_tx(8'h80, 8'h80, 8'h00, 1);
		pll = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk("unlock", {7'h00, lock_st}, 8'h00);
		$display("test lock done");
		for (int s = 0; s < 4; s++) begin
			{st_hi, st_lo} = s[1:0];
			repeat (4) @(posedge mclk);
			#1;
			for (int k = 0; k < 4; k++) begin
				tw_master_model_inst.cond(1'b1, 1'b0);
				wb("sel ack", {FIXED_ADDR_BITS, k[1:0], 1'b0}, k != s);
				wb("ignored", 8'h81, k != s);
				tw_master_model_inst.cond(1'b0, 1'b1);
			end
		end
		tw_master_model_inst.cond(1'b1, 1'b0);
		wb("fixed bits", {~FIXED_ADDR_BITS, st_hi, st_lo, 1'b0}, 1'b1);
		tw_master_model_inst.cond(1'b0, 1'b1);
		$display("test address done");
		rst_pulse();
		rd_tx(8'h81, 8'h20, 8'h00, 1);
		$display("test reset done");
		finish_test();
	end
endmodule // tb_top

// file: tb/tw_master_model.sv
/* Two-wire bus master model: drives SCL and releases or pulls SDA.
   Assumes the bench resolves the pulled-up SDA wire from all drivers. */
`timescale 1ns/1ps
module tw_master_model (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_drv_o
);
	// ==========================================================
	// Bus timing: 8 mclk a bit, SCL idles high
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Start (a=1,b=0) or stop (a=0,b=1)
	task automatic cond(input logic a, input logic b);
		wt(1);
		sda_drv_o = a;
		wt(3);
		scl_o = 1'b1;
		wt(4);
		sda_drv_o = b;
		wt(4);
		scl_o = b;
	endtask
	// One bit, read back at the end of SCL high
	task automatic sb(input logic b, output logic r);
		wt(1);
		sda_drv_o = b;
		wt(3);
		scl_o = 1'b1;
		wt(4);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	// Byte MSB first, then the acknowledge bit
	task automatic xb(input logic [7:0] b, input logic ab, output logic [7:0] q,
		output logic ar);
		for (int i = 7; i >= 0; i--)
			sb(b[i], q[i]);
		sb(ab, ar);
	endtask
endmodule // tw_master_model
